// [hdl/piv_ctrl.sv]
// Interrupt flags, masking and fixed-priority vectoring with AXI4-Lite access
`timescale 1ns/1ps
`default_nettype none
module piv_ctrl (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire piv_pkg::piv_evt_t evt,
  input  wire logic              ack_ready,
  input  wire logic              return_from_irq_instr,
  input  wire logic [15:0]       pc_now,
  output var  piv_pkg::piv_vec_t vec_out,
  output logic                   gdis_out,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  logic [7:0]        pflags_q, pflags_d;
  logic [7:0]        penable_q, penable_d;
  logic [7:0]        ictrl_q, ictrl_d;
  logic              gdis_q, gdis_d;
  logic [15:0]       lastvec_q, lastvec_d;
  piv_pkg::piv_vec_t vec_q, vec_d;
  logic              awv_q, awv_d;
  logic              wv_q, wv_d;
  logic [7:0]        awa_q, awa_d;
  logic [7:0]        wd_q, wd_d;
  logic              wlane_q, wlane_d;
  logic              bv_q, bv_d;
  logic [1:0]        br_q, br_d;
  logic              rv_q, rv_d;
  logic [31:0]       rd_q, rd_d;
  logic [1:0]        rr_q, rr_d;
  logic              awrdy_q, awrdy_d;
  logic              wrdy_q, wrdy_d;
  logic              ardy_q, ardy_d;
  logic              wr_fire;
  logic              periph_pend;
  logic              req_ext, req_t0, req_tck, req_per;
  logic [15:0]       sel_vec;
  logic              any_req;

  // Pending flag is a pure function of flags and enables, never stored
  // so clearing a flag drops the request in the very same cycle
  assign periph_pend = |(pflags_q & penable_q);

  // Write commits once both address and data are held and no response waits
  // Stalling behind a held response keeps bresp tied to the oldest write
  assign wr_fire = awv_q && wv_q && !bv_q;

  // Per-source request: flag and own enable, group enable for the peripheral source only, global disable
  always_comb
  begin
    req_ext = ictrl_q[piv_pkg::B_EXT_F] && ictrl_q[piv_pkg::B_EXT_EN];
    req_t0  = ictrl_q[piv_pkg::B_T0_F] && ictrl_q[piv_pkg::B_T0_EN];
    req_tck = ictrl_q[piv_pkg::B_TCK_F] && ictrl_q[piv_pkg::B_TCK_EN];
    req_per = periph_pend && ictrl_q[piv_pkg::B_PER_EN];
    any_req = !gdis_q && (req_ext | req_t0 | req_tck | req_per);
    // Fixed priority chain; lower sources wait until they are highest
    // Limitation: a source that keeps firing can starve lower vectors
    if (req_ext)
    begin
      sel_vec = piv_pkg::VEC_EXT;
    end
    else if (req_t0)
    begin
      sel_vec = piv_pkg::VEC_T0;
    end
    else if (req_tck)
    begin
      sel_vec = piv_pkg::VEC_TCK;
    end
    else if (req_per)
    begin
      sel_vec = piv_pkg::VEC_PER;
    end
    else
    begin
      sel_vec = piv_pkg::VEC_NONE;
    end
  end

  // Flag and control state: hardware set beats a same-cycle software clear
  always_comb
  begin
    logic [7:0] hw_set;
    hw_set = 8'h00;
    pflags_d  = pflags_q;
    penable_d = penable_q;
    ictrl_d   = ictrl_q;
    gdis_d    = gdis_q;
    lastvec_d = lastvec_q;
    vec_d     = vec_q;
    vec_d.take = 1'b0;
    if (wr_fire && wlane_q)
    begin
      case (awa_q)
        piv_pkg::OFF_PFLAGS2:
        begin
          pflags_d = (pflags_q & ~piv_pkg::PF_WMASK)
                   | (wd_q & piv_pkg::PF_WMASK);
        end
        piv_pkg::OFF_PENABLE:
        begin
          // Enable bit 4 is unimplemented and always reads zero
          penable_d = wd_q & 8'hef;
        end
        piv_pkg::OFF_IRQCTRL:
        begin
          ictrl_d = wd_q & piv_pkg::IC_WMASK;
        end
        piv_pkg::OFF_CPUSTAT:
        begin
          gdis_d = wd_q[piv_pkg::B_GDIS];
        end
        default:
        begin
          gdis_d = gdis_q;
        end
      endcase
    end
    // Sticky event sets regardless of any enable or disable
    // Events are one-cycle pulses, so no edge detection is kept here
    hw_set[piv_pkg::B_SSP]  = evt.ssp_done;
    hw_set[piv_pkg::B_COLL] = evt.collision && evt.i2c_master;
    hw_set[piv_pkg::B_ADC]  = evt.adc_done;
    hw_set[piv_pkg::B_CAP4] = evt.cap4;
    hw_set[piv_pkg::B_CAP3] = evt.cap3;
    pflags_d = pflags_d | hw_set;
    // Buffer status bits follow hardware only
    pflags_d[piv_pkg::B_TX2] = evt.tx2_empty;
    pflags_d[piv_pkg::B_RX2] = evt.rx2_full;
    // Unimplemented bit reads zero whatever software writes
    pflags_d[4] = 1'b0;
    // Core source flags follow the same set-wins rule as the peripherals
    if (evt.ext_edge)
    begin
      ictrl_d[piv_pkg::B_EXT_F] = 1'b1;
    end
    if (evt.t0_ovf)
    begin
      ictrl_d[piv_pkg::B_T0_F] = 1'b1;
    end
    if (evt.tck_edge)
    begin
      ictrl_d[piv_pkg::B_TCK_F] = 1'b1;
    end
    // Return re-enables; acceptance in the same cycle wins and disables
    if (return_from_irq_instr)
    begin
      gdis_d = 1'b0;
    end
    // One idle cycle after each strobe: a back-to-back take would push
    // the same return address twice before the core has redirected
    if (any_req && ack_ready && !vec_q.take)
    begin
      gdis_d         = 1'b1;
      vec_d.take     = 1'b1;
      vec_d.vector   = sel_vec;
      vec_d.ret_addr = pc_now;
      lastvec_d      = sel_vec;
    end
    ictrl_d[piv_pkg::B_PEND_F] = 1'b0;
  end

  // Flag and vector registers; global disable comes up set
  // Vector and return address hold after the strobe for a late reader
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pflags_q  <= piv_pkg::PF_RESET;
      penable_q <= piv_pkg::PE_RESET;
      ictrl_q   <= piv_pkg::IC_RESET;
      gdis_q    <= 1'b1;
      lastvec_q <= piv_pkg::VEC_NONE;
      vec_q     <= '0;
    end
    else
    begin
      pflags_q  <= pflags_d;
      penable_q <= penable_d;
      ictrl_q   <= ictrl_d;
      gdis_q    <= gdis_d;
      lastvec_q <= lastvec_d;
      vec_q     <= vec_d;
    end
  end

  // AXI4-Lite channel capture and responses
  always_comb
  begin
    logic [31:0] rv;
    rv    = 32'h0000_0000;
    awv_d = awv_q;
    awa_d = awa_q;
    wv_d  = wv_q;
    wd_d  = wd_q;
    wlane_d = wlane_q;
    bv_d  = bv_q;
    br_d  = br_q;
    rv_d  = rv_q;
    rd_d  = rd_q;
    rr_d  = rr_q;
    if (s_axi_awvalid && !awv_q)
    begin
      awv_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wv_q)
    begin
      wv_d    = 1'b1;
      wd_d    = s_axi_wdata[7:0];
      wlane_d = s_axi_wstrb[0];
    end
    // Commit frees both slots at once; the response then waits for bready
    if (wr_fire)
    begin
      awv_d = 1'b0;
      wv_d  = 1'b0;
      bv_d  = 1'b1;
      br_d  = (awa_q == piv_pkg::OFF_VECTOR || awa_q == piv_pkg::OFF_PFLAGS2
            || awa_q == piv_pkg::OFF_PENABLE || awa_q == piv_pkg::OFF_IRQCTRL
            || awa_q == piv_pkg::OFF_CPUSTAT)
            ? piv_pkg::RESP_OKAY : piv_pkg::RESP_SLVERR;
    end
    else if (bv_q && s_axi_bready)
    begin
      bv_d = 1'b0;
    end
    // Read path; the pending flag is synthesised on the fly
    // Data are latched at the handshake edge, unmapped reads get SLVERR
    if (s_axi_arvalid && !rv_q)
    begin
      rr_d = piv_pkg::RESP_OKAY;
      case (s_axi_araddr)
        piv_pkg::OFF_PFLAGS2: rv[7:0] = pflags_q;
        piv_pkg::OFF_PENABLE: rv[7:0] = penable_q;
        piv_pkg::OFF_IRQCTRL: rv[7:0] = {periph_pend, ictrl_q[6:0]};
        piv_pkg::OFF_CPUSTAT: rv[piv_pkg::B_GDIS] = gdis_q;
        piv_pkg::OFF_VECTOR:  rv[15:0] = lastvec_q;
        default:              rr_d = piv_pkg::RESP_SLVERR;
      endcase
      rv_d = 1'b1;
      rd_d = rv;
    end
    else if (rv_q && s_axi_rready)
    begin
      rv_d = 1'b0;
    end
    // Readies are the slot-empty state one cycle ahead, kept in flops so
    // that no bus output passes through gates on its way out
    awrdy_d = !awv_d;
    wrdy_d  = !wv_d;
    ardy_d  = !rv_d;
  end

  // Bus registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      awv_q <= 1'b0;
      awa_q <= 8'h00;
      wv_q  <= 1'b0;
      wd_q  <= 8'h00;
      wlane_q <= 1'b0;
      bv_q  <= 1'b0;
      br_q  <= piv_pkg::RESP_OKAY;
      rv_q  <= 1'b0;
      rd_q  <= 32'h0000_0000;
      rr_q  <= piv_pkg::RESP_OKAY;
      // Slots come up empty, so every ready starts high
      awrdy_q <= 1'b1;
      wrdy_q  <= 1'b1;
      ardy_q  <= 1'b1;
    end
    else
    begin
      awv_q <= awv_d;
      awa_q <= awa_d;
      wv_q  <= wv_d;
      wd_q  <= wd_d;
      wlane_q <= wlane_d;
      bv_q  <= bv_d;
      br_q  <= br_d;
      rv_q  <= rv_d;
      rd_q  <= rd_d;
      rr_q  <= rr_d;
      awrdy_q <= awrdy_d;
      wrdy_q  <= wrdy_d;
      ardy_q  <= ardy_d;
    end
  end

  // Every output is a flop; ready is high while its holding slot is empty
  assign s_axi_awready = awrdy_q;
  assign s_axi_wready  = wrdy_q;
  assign s_axi_arready = ardy_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;
  assign vec_out       = vec_q;
  assign gdis_out      = gdis_q;

endmodule
`default_nettype wire

// [hdl/piv_pkg.sv]
// Package with register map, field positions, vectors and reset values
package piv_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFF_PFLAGS2 = 8'h10;
  localparam logic [7:0] OFF_PENABLE = 8'h14;
  localparam logic [7:0] OFF_IRQCTRL = 8'h18;
  localparam logic [7:0] OFF_CPUSTAT = 8'h1c;
  localparam logic [7:0] OFF_VECTOR  = 8'h20;
  // Flag bit positions in peripheral_flags_two
  localparam int B_SSP   = 7;
  localparam int B_COLL  = 6;
  localparam int B_ADC   = 5;
  localparam int B_CAP4  = 3;
  localparam int B_CAP3  = 2;
  localparam int B_TX2   = 1;
  localparam int B_RX2   = 0;
  // Software-writable flag bits (bit 4 unimplemented, 1:0 hardware)
  localparam logic [7:0] PF_WMASK = 8'hec;
  // Reset values
  localparam logic [7:0] PF_RESET = 8'h02;
  localparam logic [7:0] PE_RESET = 8'h00;
  // irq_status_ctrl: enables 3:0, flags 7:4
  localparam int B_EXT_EN  = 0;
  localparam int B_T0_EN   = 1;
  localparam int B_TCK_EN  = 2;
  localparam int B_PER_EN  = 3;
  localparam int B_EXT_F   = 4;
  localparam int B_T0_F    = 5;
  localparam int B_TCK_F   = 6;
  localparam int B_PEND_F  = 7;
  localparam logic [7:0] IC_RESET = 8'h00;
  localparam logic [7:0] IC_WMASK = 8'h7f;
  // cpu_status_reg: global disable bit
  localparam int B_GDIS = 4;
  // Vector addresses
  localparam logic [15:0] VEC_EXT  = 16'h0008;
  localparam logic [15:0] VEC_T0   = 16'h0010;
  localparam logic [15:0] VEC_TCK  = 16'h0018;
  localparam logic [15:0] VEC_PER  = 16'h0020;
  localparam logic [15:0] VEC_NONE = 16'h0000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Event inputs from peripherals and core sources
  typedef struct packed {
    logic ssp_done;
    logic collision;
    logic i2c_master;
    logic adc_done;
    logic cap4;
    logic cap3;
    logic tx2_empty;
    logic rx2_full;
    logic ext_edge;
    logic t0_ovf;
    logic tck_edge;
  } piv_evt_t;

  // Vectoring request toward the core
  typedef struct packed {
    logic        take;
    logic [15:0] vector;
    logic [15:0] ret_addr;
  } piv_vec_t;
endpackage

// [sim/piv_chk.sv]
// Concurrent checks on the vectoring outputs of the interrupt block
`timescale 1ns/1ps
`default_nettype none
module piv_chk (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              ack_ready,
  input wire logic              return_from_irq_instr,
  input wire logic [15:0]       pc_now,
  input wire piv_pkg::piv_vec_t vec_out,
  input wire logic              gdis_out,
  input wire logic              s_axi_bvalid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Acceptance only through an open gate and a ready core
  take_gate_a: assert property (
    vec_out.take |-> !$past(gdis_out) && $past(ack_ready))
    else $error("vector taken while disabled or core busy");
  take_gdis_a: assert property (
    vec_out.take |-> gdis_out)
    else $error("global disable not set with vector");
  take_pulse_a: assert property (
    vec_out.take |=> !vec_out.take)
    else $error("vector strobe longer than one cycle");
  ret_addr_a: assert property (
    vec_out.take |-> vec_out.ret_addr == $past(pc_now))
    else $error("pushed address is not the interrupted pc");
  // Only the four fixed vectors ever leave the block
  vec_legal_a: assert property (
    vec_out.take |-> vec_out.vector inside
      {16'h0008, 16'h0010, 16'h0018, 16'h0020})
    else $error("vector outside the fixed table");
  // The disable bit moves only by return, acceptance or a bus write
  ret_clear_a: assert property (
    return_from_irq_instr |=> !gdis_out || vec_out.take)
    else $error("return left interrupts disabled");
  gdis_rise_a: assert property (
    $rose(gdis_out) |-> vec_out.take || s_axi_bvalid)
    else $error("global disable set without cause");
  gdis_fall_a: assert property (
    $fell(gdis_out) |-> $past(return_from_irq_instr) || s_axi_bvalid)
    else $error("global disable cleared without cause");
endmodule

bind piv_ctrl piv_chk chk_u (
  .clk, .rstn, .ack_ready, .return_from_irq_instr, .pc_now, .vec_out, .gdis_out,
  .s_axi_bvalid
);
`default_nettype wire

// [sim/piv_core_model.sv]
// Core-side model: program counter, return stack and return strobe
`timescale 1ns/1ps
`default_nettype none
module piv_core_model (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire piv_pkg::piv_vec_t vec_out,
  output logic                   ack_ready,
  output logic                   return_from_irq_instr,
  output logic [15:0]            pc_now
);
  logic        slow;
  int          n_take;
  logic [15:0] vq[$];
  logic [15:0] stk[$];

  // Known levels before the first reset edge arrives
  initial
  begin
    slow = 1'b0;
    return_from_irq_instr = 1'b0;
    ack_ready = 1'b1;
    pc_now = 16'h0100;
  end

  // Fetch runs on; a vector or a return redirects it
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pc_now <= 16'h0100;
      ack_ready <= 1'b1;
      n_take <= 0;
    end
    else
    begin
      ack_ready <= slow ? !ack_ready : 1'b1; // Slow core stalls every other cycle
      pc_now <= pc_now + 16'h0001;
      if (return_from_irq_instr)
        pc_now <= stk.pop_back();
      if (vec_out.take)
      begin
        stk.push_back(vec_out.ret_addr);
        vq.push_back(vec_out.vector);
        pc_now <= vec_out.vector;
        n_take <= n_take + 1;
      end
    end
  end

  // Return strobe, one cycle, launched just after an edge
  task automatic do_return;
    @(posedge clk);
    return_from_irq_instr <= 1'b1;
    @(posedge clk);
    return_from_irq_instr <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [sim/test_prioritized_interrupt_vectoring.sv]
// Directed bench for the interrupt vectoring block over its register bus
`timescale 1ns/1ps
`default_nettype none
module test_prioritized_interrupt_vectoring;
  logic              clk, rstn, ack_ready, return_from_irq_instr, gdis_out;
  logic [10:0]       evt;
  logic [15:0]       pc_now;
  piv_pkg::piv_vec_t vec_out;
  logic [7:0]        s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  int                mismatches, total_checks, i;
  logic [7:0]        clr [3];

  piv_ctrl dut_u (
    .clk, .rstn, .evt(piv_pkg::piv_evt_t'(evt)), .ack_ready, .return_from_irq_instr,
    .pc_now, .vec_out, .gdis_out, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  piv_core_model core_u (.clk, .rstn, .vec_out, .ack_ready, .return_from_irq_instr, .pc_now);

  // 10 MHz clock
  always #50 clk = ~clk;

  task automatic chk(input string nm, input logic [33:0] ex, got);
    total_checks++;
    if (got !== ex)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // A wait that used up its bound ends the run
  task automatic tmo(input int n);
    if (n >= 50)
    begin
      mismatches++;
      $display("mismatch wait expected 0 seen %0d", n);
      final_report();
    end
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, d, input logic [1:0] er = 2'h0);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    tmo(n);
    chk("bresp", {32'h0, er}, {32'h0, s_axi_bresp});
  endtask

  task automatic axr(input logic [7:0] a, d, input logic [1:0] er = 2'h0);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    tmo(n);
    chk("rdata", {er, 24'h0, d}, {s_axi_rresp, s_axi_rdata});
  endtask

  task automatic pulse(input logic [10:0] m);
    @(posedge clk);
    evt <= evt | m;
    @(posedge clk);
    evt <= evt & ~m;
  endtask

  task automatic wait_take(input int k);
    int n;
    for (n = 0; n < 50 && core_u.n_take < k; n++)
      @(posedge clk);
    tmo((core_u.n_take < k) ? 50 : 0);
  endtask

  initial
  begin
    {clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'h1;
    evt = 11'h010;
    mismatches = 0;
    total_checks = 0;
    clr = '{8'h6f, 8'h4f, 8'h0f};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    // Reset state, unmapped access, write without byte strobe
    axr(piv_pkg::OFF_PFLAGS2, 8'h02);
    axr(8'h00, 8'h00, piv_pkg::RESP_SLVERR);
    axw(8'h04, 8'h00, piv_pkg::RESP_SLVERR);
    s_axi_wstrb <= 4'h0;
    axw(piv_pkg::OFF_CPUSTAT, 8'h00);
    s_axi_wstrb <= 4'h1;
    axr(piv_pkg::OFF_CPUSTAT, 8'h10);
    $display("test reset done");
    // Flags with every enable off; collision needs master mode
    pulse(11'h200);
    axr(piv_pkg::OFF_PFLAGS2, 8'h02);
    evt <= evt | 11'h108;
    pulse(11'h6e0);
    axr(piv_pkg::OFF_PFLAGS2, 8'hef);
    axw(piv_pkg::OFF_PFLAGS2, 8'h00);
    axr(piv_pkg::OFF_PFLAGS2, 8'h03);
    $display("test flags done");
    // All four sources pending while disabled
    axw(piv_pkg::OFF_PENABLE, 8'h04);
    axw(piv_pkg::OFF_IRQCTRL, 8'h0f);
    pulse(11'h027);
    axr(piv_pkg::OFF_IRQCTRL, 8'hff);
    chk("early", 34'h0, 34'(core_u.n_take));
    // Open the gate; slow core; service in priority order
    core_u.slow <= 1'b1;
    axw(piv_pkg::OFF_CPUSTAT, 8'h00);
    for (i = 0; i < 3; i++)
    begin
      wait_take(i + 1);
      axw(piv_pkg::OFF_IRQCTRL, clr[i]);
      core_u.do_return();
    end
    wait_take(4);
    axw(piv_pkg::OFF_PFLAGS2, 8'h00);
    core_u.do_return();
    repeat (10) @(posedge clk);
    chk("takes", 34'h4, 34'(core_u.n_take));
    for (i = 0; i < 4; i++)
      chk("vector", 34'(8 * (i + 1)), 34'(core_u.vq[i]));
    $display("test priority done");
    // Group enable off masks the peripheral source only
    axw(piv_pkg::OFF_CPUSTAT, 8'h10);
    axw(piv_pkg::OFF_IRQCTRL, 8'h07);
    axw(piv_pkg::OFF_CPUSTAT, 8'h00);
    pulse(11'h020);
    repeat (10) @(posedge clk);
    axr(piv_pkg::OFF_IRQCTRL, 8'h87);
    chk("masked", 34'h4, 34'(core_u.n_take));
    axw(piv_pkg::OFF_IRQCTRL, 8'h0f);
    wait_take(5);
    chk("periph", 34'h20, 34'(core_u.vq[4]));
    axw(piv_pkg::OFF_VECTOR, 8'h00);
    axr(piv_pkg::OFF_VECTOR, 8'h20);
    $display("test group done");
    final_report();
  end
endmodule
`default_nettype wire
